// >>> inc/i2cx_pkg.sv
// i2cx_pkg: shared types, command codes, reset values and timing counts
// for the two-wire 16-bit i/o expander.
// assumes a 250 MHz system clock; every constant here but ST_CHG_A, ST_CHG_B, ST_WR and ST_RD is used by i2cx_top.
package i2cx_pkg;

  // one 8-bit group per port, port a in the low byte
  typedef struct packed {
    logic [7:0] b;
    logic [7:0] a;
  } i2cx_port_t;

  // command byte values selecting the target register
  localparam logic [2:0] CMD_IN_A  = 3'h0;
  localparam logic [2:0] CMD_IN_B  = 3'h1;
  localparam logic [2:0] CMD_OUT_A = 3'h2;
  localparam logic [2:0] CMD_OUT_B = 3'h3;
  localparam logic [2:0] CMD_POL_A = 3'h4;
  localparam logic [2:0] CMD_POL_B = 3'h5;
  localparam logic [2:0] CMD_CFG_A = 3'h6;
  localparam logic [2:0] CMD_CFG_B = 3'h7;

  // register defaults: all pins inputs, outputs high, no inversion
  localparam logic [7:0] OUT_RST = 8'hFF;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'hFF;

  // top bit of the 7-bit slave address; the straps give the low six
  localparam logic ADDR_MSB = 1'h0;

  // local register port map
  localparam logic [7:0] REG_STAT = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;

  // status bit positions
  localparam int ST_CHG_A = 0;
  localparam int ST_CHG_B = 1;
  localparam int ST_WR    = 2;
  localparam int ST_RD    = 3;
  localparam int ST_W     = 4;

  // spike filter on the bus lines
  localparam int         CLK_MHZ  = 250;
  localparam int         FILT_NS  = 50;
  localparam logic [3:0] FILT_CYC = 4'((FILT_NS * CLK_MHZ + 999) / 1000);

  // edges after reset in which the input register follows the pins
  localparam logic [1:0] PRIME_CYC = 2'h3;

  // bits per byte on the serial bus
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // bus protocol states, one-hot
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_ADDR  = 7'h02,
    S_ACK_A = 7'h04,
    S_WR    = 7'h08,
    S_ACK_W = 7'h10,
    S_RD    = 7'h20,
    S_ACK_R = 7'h40
  } i2cx_state_t;

endpackage

// >>> tb/i2cx_bus_master.sv
// i2cx_bus_master: behavioural two-wire bus master
// assumes a pull-up, so a released data line reads high
`timescale 1ns/10ps
module i2cx_bus_master #(
  parameter int HALF_NS = 80  // half of the 160 ns link clock
) (
  input  wire logic sda_i,    // wired level of the data line
  output logic      scl_o,    // clock, stands high between frames
  output logic      sda_o     // 1 releases the line
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // start or repeated start; data moves 20 ns after clock low to keep hold time
  task automatic start();
    sda_o = 1'b1;
    #(HALF_NS) scl_o = 1'b1;
    #(HALF_NS) sda_o = 1'b0;
    #(HALF_NS) scl_o = 1'b0;
    #20;
  endtask
  // stop: data rises while the clock is high
  task automatic stop();
    sda_o = 1'b0;
    #(HALF_NS) scl_o = 1'b1;
    #(HALF_NS) sda_o = 1'b1;
    #(HALF_NS);
  endtask
  // one clock pulse, line sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic s);
    sda_o = b;
    #(HALF_NS - 20) scl_o = 1'b1;  // low phase includes the 20 ns hold
    #(HALF_NS) s = sda_i;
    scl_o = 1'b0;
    #20;
  endtask
  // byte out msb first, then the slave's acknowledge slot
  task automatic put(input logic [7:0] d, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, nak);
  endtask
  // byte in msb first, then our acknowledge or final nack
  task automatic get(input logic nak_i, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(nak_i, s);
  endtask
endmodule

// >>> tb/i2cx_monitor.sv
// i2cx_monitor: port-level checks for i2cx_top
// assumes the straps are tied only low or high while it watches
`timescale 1ns/10ps
module i2cx_monitor
  import i2cx_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic        addr_strap_0_i,
  input wire logic        addr_strap_1_i,
  input wire logic        addr_strap_2_i,
  input wire i2cx_port_t  pin_i,
  input wire i2cx_port_t  pin_o,
  input wire i2cx_port_t  pin_oe_o,
  input wire logic        alert_n_o,
  input wire logic        alert_oe_o,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // start: data falls while the clock is high
  sequence s_start;
    scl_i && $fell(sda_i);
  endsequence
  // local read strobe at one address
  sequence s_rd_at(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  reset_quiet_a: assert property (
    $rose(rst_b_i) |-> pin_oe_o == 16'h0 && pin_o == 16'hFFFF && !alert_oe_o && !sda_oe_o)
    else $error("outputs not at reset values");
  rd_idle_zero_a: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("read data outside its cycle");
  rd_width_a: assert property (
    s_rd_at(REG_STAT) or s_rd_at(REG_MASK) |=> reg_rdata_o[31:4] == 28'h0)
    else $error("unused status bits not zero");
  rd_unmapped_a: assert property (
    s_rd_at(8'h0C) |=> reg_rdata_o == 32'h0) else $error("unmapped read not zero");
  slave_addr_a: assert property (
    s_rd_at(REG_ADDR) |=> reg_rdata_o == {25'h0, ADDR_MSB, 1'b0, addr_strap_2_i, 1'b0,
    addr_strap_1_i, 1'b0, addr_strap_0_i}) else $error("slave address wrong");
  mask_off_a: assert property (
    reg_wr_i && reg_addr_i == REG_MASK && reg_wdata_i[3:0] == 4'h0 |-> ##[1:2] !irq_o)
    else $error("irq with empty mask");
  sda_scl_low_a: assert property (
    $changed(sda_oe_o) |-> !scl_i) else $error("data line moved with clock high");
  start_quiet_a: assert property (
    s_start |-> !sda_oe_o [*8]) else $error("data driven at start");
  alert_rise_a: assert property (
    !alert_oe_o && $stable(pin_oe_o) && $changed(pin_i & ~pin_oe_o) |-> ##[1:8] alert_oe_o)
    else $error("alert missed an input change");
  alert_outputs_a: assert property (
    (pin_oe_o == 16'hFFFF) [*3] |-> !alert_oe_o) else $error("alert with no inputs");
endmodule

// >>> tb/tb_top.sv
// tb_top: self-checking bench for i2cx_top with a bus master model
// assumes straps tied low or high and pull-ups on the data line
`timescale 1ns/10ps
module tb_top
  import i2cx_pkg::*;
  ;
  localparam logic [6:0] SLV = 7'h01;  // strap 0 high, others low
  logic        sys_clk_i, rst_b_i, scl_i, sda_i, sda_o, sda_oe_o, m_sda;
  logic        addr_strap_0_i, addr_strap_1_i, addr_strap_2_i;
  logic        alert_n_o, alert_oe_o, reg_wr_i, reg_rd_i, irq_o;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  i2cx_port_t  pin_i, pin_o, pin_oe_o, pin_ext;
  int          miscompares, comparisons;
  // wired data line; a pin reads its driven value where enabled
  assign sda_i = m_sda & ~(sda_oe_o & ~sda_o);
  assign pin_i = i2cx_port_t'((pin_oe_o & pin_o) | (~pin_oe_o & pin_ext));
  i2cx_top dut (.*);
  i2cx_bus_master m (.sda_i(sda_i), .scl_o(scl_i), .sda_o(m_sda));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic set_pins(input logic [15:0] v);
    @(posedge sys_clk_i);
    pin_ext <= v;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(n, e, reg_rdata_o);
  endtask
  // bounded wait on alert (sel 0) or irq (sel 1); a timeout ends the run
  task automatic wait_lvl(input logic sel, input logic lvl);
    for (int n = 0; n < 200 && (sel ? irq_o : alert_oe_o) !== lvl; n++)
      tick(1);
    chk(sel ? "irq" : "alert", {31'h0, lvl}, {31'h0, sel ? irq_o : alert_oe_o});
    if ((sel ? irq_o : alert_oe_o) !== lvl)
      results();
  endtask
  // address, command byte, then one pair of data bytes
  task automatic bus_wr(input logic [2:0] c, input logic [7:0] d0, input logic [7:0] d1);
    logic nak;
    m.start();
    m.put({SLV, 1'b0}, nak);
    chk("addr ack", 32'h0, {31'h0, nak});
    m.put({5'h0, c}, nak);
    m.put(d0, nak);
    m.put(d1, nak);
    chk("data ack", 32'h0, {31'h0, nak});
    m.stop();
  endtask
  // pointer set, repeated start, two bytes read
  task automatic bus_rd(input string n, input logic [2:0] c, input logic [15:0] e);
    logic       nak;
    logic [7:0] d0, d1;
    m.start();
    m.put({SLV, 1'b0}, nak);
    m.put({5'h0, c}, nak);
    m.start();
    m.put({SLV, 1'b1}, nak);
    chk("read ack", 32'h0, {31'h0, nak});
    m.get(1'b0, d0);
    m.get(1'b1, d1);
    m.stop();
    chk(n, {16'h0, e}, {16'h0, d1, d0});
  endtask
  task automatic t_reset();
    chk("pin_oe", 32'h0, {16'h0, pin_oe_o});
    chk("pin_o", 32'hFFFF, {16'h0, pin_o});
    chk("alert_n", 32'h0, {31'h0, alert_n_o});
    reg_chk("slave addr", REG_ADDR, {25'h0, SLV});
    bus_rd("out dflt", CMD_OUT_A, {OUT_RST, OUT_RST});
    bus_rd("pol dflt", CMD_POL_A, {POL_RST, POL_RST});
    bus_rd("cfg dflt", CMD_CFG_A, {CFG_RST, CFG_RST});
    $display("reset test done");
  endtask
  task automatic t_regs();
    bus_wr(CMD_OUT_A, 8'h55, 8'h0F);
    tick(2);
    chk("pin_o", 32'h0F55, {16'h0, pin_o});
    bus_rd("out back", CMD_OUT_A, 16'h0F55);
    bus_wr(CMD_POL_A, 8'h3C, 8'h00);
    bus_rd("pol back", CMD_POL_A, 16'h003C);
    set_pins(16'hA55A);
    wait_lvl(1'b0, 1'b1);
    bus_rd("inverted in", CMD_IN_A, 16'hA566);
    wait_lvl(1'b0, 1'b0);
    $display("register test done");
  endtask
  task automatic t_alert();
    reg_wr(REG_STAT, 32'hF);
    reg_wr(REG_MASK, 32'h1);
    tick(3);
    chk("irq idle", 32'h0, {31'h0, irq_o});
    set_pins(16'hA55B);
    wait_lvl(1'b0, 1'b1);
    wait_lvl(1'b1, 1'b1);
    reg_chk("stat", REG_STAT, 32'h1);
    reg_wr(REG_MASK, 32'h0);
    tick(3);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    reg_wr(REG_MASK, 32'h1);
    tick(3);
    chk("irq unmasked", 32'h1, {31'h0, irq_o});
    reg_wr(REG_STAT, 32'h1);
    tick(3);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    chk("alert held", 32'h1, {31'h0, alert_oe_o});
    set_pins(16'hA55A);
    wait_lvl(1'b0, 1'b0);
    reg_chk("unmapped", 8'h0C, 32'h0);
    reg_wr(REG_ADDR, 32'h7F);
    reg_chk("addr ro", REG_ADDR, {25'h0, SLV});
    $display("alert test done");
  endtask
  task automatic t_dir();
    bus_wr(CMD_CFG_A, 8'hF0, 8'h0F);
    tick(2);
    chk("pin_oe", 32'hF00F, {16'h0, pin_oe_o});
    bus_rd("cfg back", CMD_CFG_A, 16'h0FF0);
    bus_rd("mixed in", CMD_IN_A, 16'h0569);
    bus_wr(CMD_CFG_A, 8'h00, 8'h00);
    set_pins(16'h5AA5);
    tick(20);
    chk("all out oe", 32'hFFFF, {16'h0, pin_oe_o});
    chk("alert no in", 32'h0, {31'h0, alert_oe_o});
    $display("direction test done");
  endtask
  task automatic t_refuse();
    logic nak;
    m.start();
    m.put({SLV ^ 7'h02, 1'b0}, nak);
    m.stop();
    chk("foreign ack", 32'h1, {31'h0, nak});
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    tick(5);
    chk("oe in reset", 32'h0, {16'h0, pin_oe_o});
    @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    tick(4);
    bus_rd("cfg again", CMD_CFG_A, 16'hFFFF);
    $display("refusal test done");
  endtask
  initial
  begin
    {rst_b_i, reg_wr_i, reg_rd_i, addr_strap_2_i, addr_strap_1_i} = '0;
    addr_strap_0_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    pin_ext = 16'h0000;
    miscompares = 0;
    comparisons = 0;
    repeat (20) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    tick(4);
    t_reset();
    t_regs();
    t_alert();
    t_dir();
    t_refuse();
    results();
  end
endmodule
bind i2cx_top i2cx_monitor mon (.*);

// >>> verilog/i2cx_top.sv
// i2cx_top: two-wire bus slave with sixteen general purpose pins, a change
// alert and a local status/mask register port.
// assumes scl, sda, straps and pins are asynchronous to sys_clk_i; the
// wired level of sda and alert is resolved outside from the enables.
`timescale 1ns/10ps

// Notes on behaviour
// - sixteen pins, two ports, four registers each
// - all pins inputs, undriven after reset
// - direction bit per pin sets input/output
// - output register drives pins; inputs captured
// - polarity bit complements input register read
// - every register readable over the bus
// - alert low while input differs from register
// - reset loads defaults, protocol machine idles
// - three four-level straps give 64 addresses
// - works at standard, fast, fast-plus rates
// - spike filter on clock and data lines
module i2cx_top
  import i2cx_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        addr_strap_0_i,
  input  wire logic        addr_strap_1_i,
  input  wire logic        addr_strap_2_i,
  input  wire i2cx_port_t  pin_i,
  output i2cx_port_t       pin_o,
  output i2cx_port_t       pin_oe_o,
  output logic             alert_n_o,
  output logic             alert_oe_o,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  output logic             irq_o
);

  // next pointer within a register pair (a <-> b)
  function automatic logic [2:0] pair_next(input logic [2:0] p);
    pair_next = {p[2:1], ~p[0]};
  endfunction

  // strap level class from three samples: idle, after start, scl low
  function automatic logic [1:0] strap_code(input logic s_idle,
                                            input logic s_start,
                                            input logic s_low);
    if (!s_idle)
      strap_code = 2'h0;       // tied low
    else if (!s_start)
      strap_code = 2'h3;       // follows sda
    else if (!s_low)
      strap_code = 2'h2;       // follows scl
    else
      strap_code = 2'h1;       // tied high
  endfunction

  // raw asynchronous inputs, synchronised as one vector
  localparam int SYNC_W = 21;
  logic [SYNC_W-1:0] sync1_r;  // first stage, read only by sync2_r
  logic [SYNC_W-1:0] sync2_r;  // safe copy
  wire  [SYNC_W-1:0] raw_in = {pin_i, addr_strap_2_i, addr_strap_1_i,
                               addr_strap_0_i, sda_i, scl_i};

  // two-flop synchroniser
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync1_r <= {SYNC_W{1'b1}};
      sync2_r <= {SYNC_W{1'b1}};
    end
    else
    begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  wire i2cx_port_t pin_s   = sync2_r[20:5];  // sampled pin levels
  wire logic [2:0] strap_s = sync2_r[4:2];   // sampled straps
  wire logic [1:0] line_s  = sync2_r[1:0];   // {sda, scl}

  // spike filter: a line changes only after FILT_CYC stable cycles
  logic [1:0] flt_r;                         // filtered {sda, scl}
  logic [1:0] flt_d_r;                       // previous filtered value
  logic [3:0] fcnt_r [2];                    // stability counters

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      flt_r     <= 2'h3;
      flt_d_r   <= 2'h3;
      fcnt_r[0] <= 4'h0;
      fcnt_r[1] <= 4'h0;
    end
    else
    begin
      flt_d_r <= flt_r;
      for (int k = 0; k < 2; k++)
      begin
        if (line_s[k] == flt_r[k])
          fcnt_r[k] <= 4'h0;                 // short pulse discarded
        else if (fcnt_r[k] == FILT_CYC - 4'h1)
        begin
          flt_r[k]  <= line_s[k];
          fcnt_r[k] <= 4'h0;
        end
        else
          fcnt_r[k] <= fcnt_r[k] + 4'h1;
      end
    end
  end

  // bus events; 13 cycles of filter is far below the 260 ns minimum
  // clock phase at the fastest rate, so no edge is swallowed
  wire scl_rise = flt_r[0] & ~flt_d_r[0];
  wire scl_fall = ~flt_r[0] & flt_d_r[0];
  wire bus_start = flt_r[0] & flt_d_r[0] & flt_d_r[1] & ~flt_r[1];
  wire bus_stop  = flt_r[0] & flt_d_r[0] & ~flt_d_r[1] & flt_r[1];

  // protocol machine state
  i2cx_state_t st_r;
  logic [3:0]  cnt_r;          // rising edges seen in the current byte
  logic [7:0]  sh_r;           // receive shifter
  logic [7:0]  tx_r;           // transmit shifter
  logic [2:0]  ptr_r;          // selected register
  logic        first_r;        // next written byte is the command byte
  logic        rw_r;           // direction bit of the address byte
  logic        sda_oe_r;       // pulling sda low
  logic        acked_r;        // master acked the last read byte

  // straps: samples and decoded address
  logic [2:0]  smp_idle_r;
  logic [2:0]  smp_start_r;
  logic [2:0]  smp_low_r;
  wire  [6:0]  slave_addr = {ADDR_MSB,
                             strap_code(smp_idle_r[2], smp_start_r[2], smp_low_r[2]),
                             strap_code(smp_idle_r[1], smp_start_r[1], smp_low_r[1]),
                             strap_code(smp_idle_r[0], smp_start_r[0], smp_low_r[0])};

  // device registers
  i2cx_port_t out_r;           // output values
  i2cx_port_t pol_r;           // read inversion
  i2cx_port_t cfg_r;           // 1 = input
  i2cx_port_t in_r;            // latched input state
  i2cx_port_t oe_r;            // registered drive enables
  logic [1:0] prime_r;         // edges left in which in_r follows the pins
  // the synchroniser shows its reset ones for two edges, so in_r tracks
  // the pins until real levels have arrived, with the alert held off
  wire        priming = (prime_r != 2'h0);

  // byte-level strobes
  wire byte_end = (cnt_r == BYTE_BITS) & scl_fall;
  wire addr_hit = (sh_r[7:1] == slave_addr);
  wire wr_byte  = (st_r == S_WR) & byte_end & ~first_r;
  wire cmd_byte = (st_r == S_WR) & byte_end & first_r;
  wire rd_load  = scl_fall & (((st_r == S_ACK_A) & rw_r) |
                              ((st_r == S_ACK_R) & acked_r));

  // read view of the pins with inversion applied
  wire i2cx_port_t in_view = pin_s ^ pol_r;
  logic [7:0] rd_byte;

  // read multiplexer over all eight registers
  always_comb
  begin
    case (ptr_r)
      CMD_IN_A:  rd_byte = in_view.a;
      CMD_IN_B:  rd_byte = in_view.b;
      CMD_OUT_A: rd_byte = out_r.a;
      CMD_OUT_B: rd_byte = out_r.b;
      CMD_POL_A: rd_byte = pol_r.a;
      CMD_POL_B: rd_byte = pol_r.b;
      CMD_CFG_A: rd_byte = cfg_r.a;
      CMD_CFG_B: rd_byte = cfg_r.b;
      default:   rd_byte = 8'h00;
    endcase
  end

  // protocol machine; start and stop win over any bit activity
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_r     <= S_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      ptr_r    <= CMD_IN_A;
      first_r  <= 1'b0;
      rw_r     <= 1'b0;
      sda_oe_r <= 1'b0;
      acked_r  <= 1'b0;
    end
    else if (bus_start)
    begin
      st_r     <= S_ADDR;                               // repeated start too
      cnt_r    <= 4'h0;
      sda_oe_r <= 1'b0;
    end
    else if (bus_stop)
    begin
      st_r     <= S_IDLE;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      if (scl_rise)
      begin
        sh_r  <= {sh_r[6:0], flt_r[1]};
        cnt_r <= cnt_r + 4'h1;
      end
      case (st_r)
        S_IDLE: ;                                       // wait for start
        S_ADDR:
          if (byte_end)
          begin
            cnt_r <= 4'h0;
            if (addr_hit)
            begin
              st_r     <= S_ACK_A;
              sda_oe_r <= 1'b1;
              rw_r     <= sh_r[0];
              first_r  <= ~sh_r[0];
            end
            else
              st_r <= S_IDLE;                           // not ours
          end
        S_ACK_A:
          if (scl_fall)
          begin
            cnt_r <= 4'h0;
            if (rw_r)
            begin
              st_r     <= S_RD;
              sda_oe_r <= ~rd_byte[7];
              tx_r     <= {rd_byte[6:0], 1'b0};
              ptr_r    <= pair_next(ptr_r);
            end
            else
            begin
              st_r     <= S_WR;
              sda_oe_r <= 1'b0;
            end
          end
        S_WR:
          if (byte_end)
          begin
            st_r     <= S_ACK_W;
            sda_oe_r <= 1'b1;
            cnt_r    <= 4'h0;
            first_r  <= 1'b0;
            if (cmd_byte)
              ptr_r <= sh_r[2:0];
            else
              ptr_r <= pair_next(ptr_r);
          end
        S_ACK_W:
          if (scl_fall)
          begin
            st_r     <= S_WR;
            sda_oe_r <= 1'b0;
            cnt_r    <= 4'h0;
          end
        S_RD:
          if (byte_end)
          begin
            st_r     <= S_ACK_R;                        // release for master ack
            sda_oe_r <= 1'b0;
            cnt_r    <= 4'h0;
          end
          else if (scl_fall)
          begin
            sda_oe_r <= ~tx_r[7];
            tx_r     <= {tx_r[6:0], 1'b0};
          end
        S_ACK_R:
          if (scl_rise)
            acked_r <= ~flt_r[1];
          else if (scl_fall)
          begin
            cnt_r <= 4'h0;
            if (acked_r)
            begin
              st_r     <= S_RD;
              sda_oe_r <= ~rd_byte[7];
              tx_r     <= {rd_byte[6:0], 1'b0};
              ptr_r    <= pair_next(ptr_r);
            end
            else
              st_r <= S_IDLE;                           // nack ends the read
          end
        default:
          st_r <= S_IDLE;
      endcase
    end
  end

  // strap sampling: idle, just after start, first low clock phase
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      smp_idle_r  <= 3'h0;
      smp_start_r <= 3'h7;                              // tied low/high decode
      smp_low_r   <= 3'h7;                              // before a first start
    end
    else
    begin
      if ((st_r == S_IDLE) & (flt_r == 2'h3) & ~bus_start)
        smp_idle_r <= strap_s;
      if (bus_start)
        smp_start_r <= strap_s;
      if ((st_r == S_ADDR) & (cnt_r == 4'h0) & ~flt_r[0] & ~flt_d_r[0])
        smp_low_r <= strap_s;
    end
  end

  // register writes from the bus and input capture
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      out_r   <= {OUT_RST, OUT_RST};
      pol_r   <= {POL_RST, POL_RST};
      cfg_r   <= {CFG_RST, CFG_RST};
      in_r    <= 16'h0000;
      prime_r <= PRIME_CYC;
    end
    else
    begin
      if (priming)
        prime_r <= prime_r - 2'h1;
      if (wr_byte)
      begin
        case (ptr_r)
          CMD_OUT_A: out_r.a <= sh_r;
          CMD_OUT_B: out_r.b <= sh_r;
          CMD_POL_A: pol_r.a <= sh_r;
          CMD_POL_B: pol_r.b <= sh_r;
          CMD_CFG_A: cfg_r.a <= sh_r;
          CMD_CFG_B: cfg_r.b <= sh_r;
          default: ;                                    // input regs read-only
        endcase
      end
      // a read of a port captures it, which also clears its alert
      if (priming | (rd_load & (ptr_r == CMD_IN_A)))
        in_r.a <= pin_s.a;
      if (priming | (rd_load & (ptr_r == CMD_IN_B)))
        in_r.b <= pin_s.b;
    end
  end

  // mismatch on pins set as inputs; returning inputs clear it too
  // held off while in_r is still being primed after reset
  wire mis_a = ~priming & (|((pin_s.a ^ in_r.a) & cfg_r.a));
  wire mis_b = ~priming & (|((pin_s.b ^ in_r.b) & cfg_r.b));
  logic mis_a_d_r;
  logic mis_b_d_r;
  logic alert_oe_r;

  // pin drive and alert, all registered
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      oe_r       <= 16'h0000;
      alert_oe_r <= 1'b0;
      mis_a_d_r  <= 1'b0;
      mis_b_d_r  <= 1'b0;
    end
    else
    begin
      oe_r       <= ~cfg_r;
      alert_oe_r <= mis_a | mis_b;
      mis_a_d_r  <= mis_a;
      mis_b_d_r  <= mis_b;
    end
  end

  // local status, mask and read port
  logic [ST_W-1:0] stat_r;
  logic [ST_W-1:0] mask_r;
  logic [31:0]     rdata_r;
  logic            irq_r;
  wire  [ST_W-1:0] stat_set = {rd_load & ~ptr_r[2] & ~ptr_r[1],
                               wr_byte,
                               mis_b & ~mis_b_d_r,
                               mis_a & ~mis_a_d_r};
  wire  [ST_W-1:0] stat_clr = (reg_wr_i & (reg_addr_i == REG_STAT)) ?
                              reg_wdata_i[ST_W-1:0] : {ST_W{1'b0}};
  // set wins over a write-one-to-clear in the same cycle
  wire  [ST_W-1:0] stat_nxt = (stat_r & ~stat_clr) | stat_set;
  wire  [31:0]     rd_mux   = (reg_addr_i == REG_STAT) ? {28'h0, stat_r} :
                              (reg_addr_i == REG_MASK) ? {28'h0, mask_r} :
                              (reg_addr_i == REG_ADDR) ? {25'h0, slave_addr} :
                              32'h0;

  // status register, mask register and one-cycle read data
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      stat_r  <= {ST_W{1'b0}};
      mask_r  <= {ST_W{1'b0}};
      rdata_r <= 32'h0;
      irq_r   <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      if (reg_wr_i & (reg_addr_i == REG_MASK))
        mask_r <= reg_wdata_i[ST_W-1:0];
      rdata_r <= reg_rd_i ? rd_mux : 32'h0;             // valid one cycle only
      irq_r   <= |(stat_r & mask_r);
    end
  end

  // sda and alert are open-drain: the data value is always low
  assign sda_o       = 1'b0;
  assign sda_oe_o    = sda_oe_r;
  assign pin_o       = out_r;
  assign pin_oe_o    = oe_r;
  assign alert_n_o   = 1'b0;
  assign alert_oe_o  = alert_oe_r;
  assign reg_rdata_o = rdata_r;
  assign irq_o       = irq_r;

endmodule
